//--- include/light_pkg.sv
`default_nettype none
package light_pkg;

   // Core timebase and the conversion and bus-timeout durations.
   localparam int CLK_HZ         = 20_000_000;
   localparam int CYC_PER_MS     = CLK_HZ / 1000;
   localparam int STD_CONV_MS    = 400;
   localparam int EXT_CONV_MS    = 80;
   localparam int TIMEOUT_MIN_MS = 25;
   localparam int TIMEOUT_MAX_MS = 35;
   localparam int STD_CONV_CYC   = STD_CONV_MS * CYC_PER_MS;
   localparam int EXT_CONV_CYC   = EXT_CONV_MS * CYC_PER_MS;
   localparam int TIMEOUT_CYC    = TIMEOUT_MIN_MS * CYC_PER_MS;
   localparam int TIMEOUT_MAX_CYC = TIMEOUT_MAX_MS * CYC_PER_MS;

   // Fixed bus address and the command byte encodings.
   localparam logic [6:0] SLAVE_ADDR     = 7'h39;
   localparam logic [7:0] CMD_POWER_DOWN = 8'h00;
   localparam logic [7:0] CMD_POWER_UP   = 8'h03;
   localparam logic [7:0] CMD_STD_RANGE  = 8'h18;
   localparam logic [7:0] CMD_EXT_RANGE  = 8'h1d;
   localparam logic [7:0] CMD_SEL_CH0    = 8'h43;
   localparam logic [7:0] CMD_SEL_CH1    = 8'h83;
   localparam logic [7:0] CMD_RESET      = 8'h00;

   // Result register layout and reset value.
   localparam int         COUNT_W      = 12;
   localparam int         VALID_BIT    = 7;
   localparam int         CHORD_LSB    = 4;
   localparam int         STEP_LSB     = 0;
   localparam logic [7:0] RESULT_RESET = 8'h00;
   localparam logic [3:0] BYTE_BITS    = 4'h8;

   typedef enum {SEL_CMD, SEL_CH0, SEL_CH1} read_sel_e;

   typedef struct packed {
      logic       valid;
      logic [2:0] chord;
      logic [3:0] step;
   } result_s;

   typedef struct packed {
      logic               channel;
      logic [COUNT_W-1:0] count;
   } conv_s;

   // First count of a chord segment, truncated to an integer.
   function automatic logic [COUNT_W-1:0] chordStart(input logic [2:0] c);
      int v;
      v = (33 * ((1 << c) - 1)) / 2;
      return COUNT_W'(v);
   endfunction : chordStart

endpackage : light_pkg
`default_nettype wire

//--- rtl/log_encoder.sv
`timescale 1ns/10ps
`default_nettype none
module log_encoder
   import light_pkg::*;
(
   input  wire logic [COUNT_W-1:0] count,
   output logic      [6:0]         code
);

   // Pick the highest chord whose start is reached, then the step inside it.
   // Counts past the last step of a chord but short of the next chord start
   // saturate at step 15, so the step never wraps back to zero.
   always_comb begin
      logic [2:0]         c;
      logic [COUNT_W-1:0] rem;
      c   = 3'h0;
      rem = '0;
      for (int i = 1; i < 8; i++) begin
         if (count >= chordStart(3'(i))) begin
            c = 3'(i);
         end
      end
      rem = (count - chordStart(c)) >> c;
      if (rem > COUNT_W'(15)) begin
         rem = COUNT_W'(15);
      end
      code = {c, rem[3:0]};
   end

endmodule : log_encoder
`default_nettype wire

//--- rtl/conv_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module conv_sequencer
   import light_pkg::*;
#(
   parameter int STD_CYC = STD_CONV_CYC,
   parameter int EXT_CYC = EXT_CONV_CYC
)(
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       enable,
   input  wire logic       extRange,
   input  wire logic [1:0] pulseEdge,
   output logic            convDone,
   output conv_s           convResult
);

   localparam int TW = $clog2(STD_CYC + 1);

   logic [TW-1:0]      timerReg, timerNext, period;
   logic               chanReg, chanNext, doneReg, doneNext;
   logic [COUNT_W-1:0] accReg, accNext;
   conv_s              resReg, resNext;

   assign period     = extRange ? TW'(EXT_CYC - 1) : TW'(STD_CYC - 1);
   assign convDone   = doneReg;
   assign convResult = resReg;

   // Integrate the active channel, then hand its count over and swap channel.
   // A range change mid-period uses >= so a shortened period still ends.
   always_comb begin
      timerNext = timerReg;
      chanNext  = chanReg;
      accNext   = accReg;
      resNext   = resReg;
      doneNext  = 1'b0;
      if (!enable) begin
         timerNext = '0;
         chanNext  = 1'b0;
         accNext   = '0;
      end else if (timerReg >= period) begin
         doneNext  = 1'b1;
         resNext   = '{channel: chanReg, count: accReg};
         chanNext  = ~chanReg;
         timerNext = '0;
         accNext   = '0;
      end else begin
         timerNext = timerReg + TW'(1);
         if (pulseEdge[chanReg] && accReg != '1) begin
            accNext = accReg + COUNT_W'(1);
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         timerReg <= '0;
         chanReg  <= 1'b0;
         accReg   <= '0;
         resReg   <= '0;
         doneReg  <= 1'b0;
      end else begin
         timerReg <= timerNext;
         chanReg  <= chanNext;
         accReg   <= accNext;
         resReg   <= resNext;
         doneReg  <= doneNext;
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   AST_STD_PERIOD: assert property (
      enable && !extRange && timerReg == TW'(STD_CYC - 1) |=> doneReg && timerReg == '0)
      else $error("standard integration did not end on time");
   AST_EXT_PERIOD: assert property (
      enable && extRange && timerReg == TW'(EXT_CYC - 1) |=> doneReg && timerReg == '0)
      else $error("extended integration did not end on time");
   AST_CH_ORDER: assert property (
      doneReg |-> resReg.channel != chanReg)
      else $error("channel did not alternate after a conversion");
   AST_RESTART: assert property (
      doneReg && enable |=> !doneReg && timerReg == TW'(1))
      else $error("next conversion did not start by itself");

endmodule : conv_sequencer
`default_nettype wire

//--- rtl/light_sensor_top.sv
`timescale 1ns/10ps
`default_nettype none
module light_sensor_top
   import light_pkg::*;
#(
   parameter int STD_CONV_CYCLES = STD_CONV_CYC,
   parameter int EXT_CONV_CYCLES = EXT_CONV_CYC,
   parameter int TIMEOUT_CYCLES  = TIMEOUT_CYC
)(
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       busClockPin,
   input  wire logic       busDataPinIn,
   output logic            busDataOut,
   output logic            busDataOe,
   input  wire logic [1:0] lightPulse
);

   localparam int LW = $clog2(TIMEOUT_CYCLES + 1);

   typedef enum {S_IDLE, S_ADDR, S_ACK, S_WRITE, S_READ, S_READ_ACK, S_IGNORE} state_e;

   logic         sclMeta, sclSync, sclPrev, sdaMeta, sdaSync, sdaPrev;
   logic [1:0]   pulseMeta, pulseSync, pulsePrev, pulseEdge;
   logic         sclRise, sclFall, startCond, stopCond, timeoutHit;
   logic [LW-1:0] lowCntReg, lowCntNext;
   state_e       stateReg, stateNext;
   logic [3:0]   bitCntReg, bitCntNext;
   logic [7:0]   shiftReg, shiftNext, txReg, txNext, readByte;
   logic         isReadReg, isReadNext, oeReg, oeNext, mAckReg, mAckNext, cmdWrite;
   logic         dataOutReg;
   logic [7:0]   cmdReg, cmdNext;
   logic         powerReg, powerNext, extReg, extNext, convDone;
   read_sel_e    readSelReg, readSelNext;
   result_s      ch0Reg, ch0Next, ch1Reg, ch1Next;
   conv_s        convResult;
   logic [6:0]   code;

   // Pins and pulses cross in through two flops; the prev stage finds edges.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sclMeta   <= 1'b1;
         sclSync   <= 1'b1;
         sclPrev   <= 1'b1;
         sdaMeta   <= 1'b1;
         sdaSync   <= 1'b1;
         sdaPrev   <= 1'b1;
         pulseMeta <= 2'h0;
         pulseSync <= 2'h0;
         pulsePrev <= 2'h0;
      end else begin
         sclMeta   <= busClockPin;
         sclSync   <= sclMeta;
         sclPrev   <= sclSync;
         sdaMeta   <= busDataPinIn;
         sdaSync   <= sdaMeta;
         sdaPrev   <= sdaSync;
         pulseMeta <= lightPulse;
         pulseSync <= pulseMeta;
         pulsePrev <= pulseSync;
      end
   end

   // Bus events seen on the synchronised lines.
   assign sclRise   = sclSync & ~sclPrev;
   assign sclFall   = ~sclSync & sclPrev;
   assign startCond = sclSync & sclPrev & sdaPrev & ~sdaSync;
   assign stopCond  = sclSync & sclPrev & ~sdaPrev & sdaSync;
   assign pulseEdge = pulseSync & ~pulsePrev;

   // Low-time watchdog: it fires once at the minimum timeout and then holds,
   // so a stuck bus is released well inside the maximum window.
   always_comb begin
      if (sclSync && sdaSync) begin
         lowCntNext = '0;
      end else if (lowCntReg == LW'(TIMEOUT_CYCLES)) begin
         lowCntNext = lowCntReg;
      end else begin
         lowCntNext = lowCntReg + LW'(1);
      end
   end
   assign timeoutHit = (lowCntReg == LW'(TIMEOUT_CYCLES - 1)) && !(sclSync && sdaSync);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         lowCntReg <= '0;
      end else begin
         lowCntReg <= lowCntNext;
      end
   end

   // Byte offered to a Receive Byte, chosen by the last selection or power command.
   always_comb begin
      case (readSelReg)
         SEL_CH0: readByte = ch0Reg;
         SEL_CH1: readByte = ch1Reg;
         default: readByte = cmdReg;
      endcase
   end

   // Bus slave. Data changes only after a clock fall, is sampled on a rise.
   // The timeout path keeps it usable on the newer bus revision too.
   always_comb begin
      stateNext  = stateReg;
      bitCntNext = bitCntReg;
      shiftNext  = shiftReg;
      txNext     = txReg;
      isReadNext = isReadReg;
      oeNext     = oeReg;
      mAckNext   = mAckReg;
      cmdWrite   = 1'b0;
      if (timeoutHit || stopCond) begin
         stateNext = S_IDLE;
         oeNext    = 1'b0;
      end else if (startCond) begin
         stateNext  = S_ADDR;
         bitCntNext = 4'h0;
         oeNext     = 1'b0;
      end else begin
         case (stateReg)
            S_ADDR, S_WRITE: begin
               if (sclRise) begin
                  shiftNext  = {shiftReg[6:0], sdaSync};
                  bitCntNext = bitCntReg + 4'h1;
               end else if (sclFall && bitCntReg == BYTE_BITS) begin
                  if (stateReg == S_WRITE) begin
                     cmdWrite   = 1'b1;
                     isReadNext = 1'b0;
                     oeNext     = 1'b1;
                     stateNext  = S_ACK;
                  end else if (shiftReg[7:1] == SLAVE_ADDR) begin
                     isReadNext = shiftReg[0];
                     oeNext     = 1'b1;
                     stateNext  = S_ACK;
                  end else begin
                     stateNext = S_IGNORE;
                  end
               end
            end
            S_ACK: begin
               if (sclFall) begin
                  bitCntNext = 4'h0;
                  if (isReadReg) begin
                     txNext    = readByte;
                     oeNext    = ~readByte[7];
                     stateNext = S_READ;
                  end else begin
                     oeNext    = 1'b0;
                     stateNext = S_WRITE;
                  end
               end
            end
            S_READ: begin
               if (sclRise) begin
                  bitCntNext = bitCntReg + 4'h1;
               end else if (sclFall) begin
                  if (bitCntReg == BYTE_BITS) begin
                     oeNext    = 1'b0;
                     stateNext = S_READ_ACK;
                  end else begin
                     txNext = {txReg[6:0], 1'b0};
                     oeNext = ~txReg[6];
                  end
               end
            end
            S_READ_ACK: begin
               if (sclRise) begin
                  mAckNext = ~sdaSync;
               end else if (sclFall) begin
                  bitCntNext = 4'h0;
                  if (mAckReg) begin
                     txNext    = readByte;
                     oeNext    = ~readByte[7];
                     stateNext = S_READ;
                  end else begin
                     stateNext = S_IGNORE;
                  end
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         stateReg   <= S_IDLE;
         bitCntReg  <= 4'h0;
         shiftReg   <= 8'h00;
         txReg      <= 8'h00;
         isReadReg  <= 1'b0;
         oeReg      <= 1'b0;
         mAckReg    <= 1'b0;
         dataOutReg <= 1'b0;
      end else begin
         stateReg   <= stateNext;
         bitCntReg  <= bitCntNext;
         shiftReg   <= shiftNext;
         txReg      <= txNext;
         isReadReg  <= isReadNext;
         oeReg      <= oeNext;
         mAckReg    <= mAckNext;
         dataOutReg <= 1'b0;
      end
   end

   // Open-drain data: the pin is only ever pulled low.
   assign busDataOut = dataOutReg;
   assign busDataOe  = oeReg;

   conv_sequencer #(
      .STD_CYC (STD_CONV_CYCLES),
      .EXT_CYC (EXT_CONV_CYCLES)
   ) u_seq (
      .core_clk   (core_clk),
      .rst        (rst),
      .enable     (powerReg),
      .extRange   (extReg),
      .pulseEdge  (pulseEdge),
      .convDone   (convDone),
      .convResult (convResult)
   );

   log_encoder u_enc (
      .count (convResult.count),
      .code  (code)
   );

   // Command decode and result registers. A finished conversion replaces a
   // whole result byte in one edge, and reads copy it whole into txReg.
   always_comb begin
      cmdNext     = cmdReg;
      powerNext   = powerReg;
      extNext     = extReg;
      readSelNext = readSelReg;
      ch0Next     = ch0Reg;
      ch1Next     = ch1Reg;
      if (cmdWrite) begin
         cmdNext = shiftReg;
         case (shiftReg)
            CMD_POWER_DOWN: begin
               powerNext   = 1'b0;
               extNext     = 1'b0;
               readSelNext = SEL_CMD;
            end
            CMD_POWER_UP: begin
               powerNext   = 1'b1;
               readSelNext = SEL_CMD;
            end
            CMD_STD_RANGE: extNext = 1'b0;
            CMD_EXT_RANGE: extNext = 1'b1;
            CMD_SEL_CH0: begin
               powerNext   = 1'b1;
               readSelNext = SEL_CH0;
            end
            CMD_SEL_CH1: begin
               powerNext   = 1'b1;
               readSelNext = SEL_CH1;
            end
            default: ;
         endcase
      end
      if (!powerReg) begin
         ch0Next = RESULT_RESET;
         ch1Next = RESULT_RESET;
      end else if (convDone) begin
         if (convResult.channel) begin
            ch1Next = '{valid: 1'b1, chord: code[6:4], step: code[3:0]};
         end else begin
            ch0Next = '{valid: 1'b1, chord: code[6:4], step: code[3:0]};
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cmdReg     <= CMD_RESET;
         powerReg   <= 1'b0;
         extReg     <= 1'b0;
         readSelReg <= SEL_CMD;
         ch0Reg     <= RESULT_RESET;
         ch1Reg     <= RESULT_RESET;
      end else begin
         cmdReg     <= cmdNext;
         powerReg   <= powerNext;
         extReg     <= extNext;
         readSelReg <= readSelNext;
         ch0Reg     <= ch0Next;
         ch1Reg     <= ch1Next;
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   AST_PWR_DOWN: assert property (
      cmdWrite && shiftReg == CMD_POWER_DOWN |=> !powerReg && !extReg && cmdReg == 8'h00)
      else $error("power-down command not applied");
   AST_PWR_UP: assert property (
      cmdWrite && shiftReg == CMD_POWER_UP |=> powerReg && readByte == 8'h03)
      else $error("power-up command not applied or not read back");
   AST_RANGE: assert property (
      cmdWrite && shiftReg == CMD_EXT_RANGE |=> extReg ##1 (extReg || $past(cmdWrite)))
      else $error("extended range not held");
   AST_SELECT: assert property (
      cmdWrite && shiftReg == CMD_SEL_CH1 |=> readSelReg == SEL_CH1 && readByte == ch1Reg)
      else $error("channel 1 selection not applied");
   AST_READBACK: assert property (
      stateReg == S_ACK && sclFall && isReadReg && !timeoutHit && !stopCond && !startCond
      |=> stateReg == S_READ && txReg == $past(readByte) && oeReg == !txReg[7])
      else $error("receive byte did not load the selected register");
   AST_VALID_SET: assert property (
      convDone && powerReg && !convResult.channel |=> ch0Reg.valid)
      else $error("valid flag not set on a transfer");
   AST_VALID_CLR: assert property (
      !powerReg |=> !ch0Reg.valid && !ch1Reg.valid && !convDone)
      else $error("valid flag or conversion while powered down");
   AST_HOLD: assert property (
      !convDone && powerReg |=> powerReg |-> $stable(ch0Reg) && $stable(ch1Reg))
      else $error("result changed without a conversion");
   AST_TIMEOUT: assert property (
      timeoutHit |=> stateReg == S_IDLE && !busDataOe)
      else $error("bus timeout did not release the slave");
   AST_ADDR_MISS: assert property (
      stateReg == S_ADDR && sclFall && bitCntReg == BYTE_BITS && shiftReg[7:1] != SLAVE_ADDR
      && !startCond && !stopCond && !timeoutHit |=> stateReg == S_IGNORE && !busDataOe)
      else $error("foreign address was acknowledged");
   AST_ZERO_CODE: assert property (
      convDone && convResult.count == '0 |-> code == 7'h00)
      else $error("zero count not coded as below detection");
   AST_CODE_RANGE: assert property (
      convDone |-> convResult.count >= chordStart(code[6:4]) && (code[3:0] == 4'hf ||
      {1'b0, convResult.count} < 13'(chordStart(code[6:4]))
      + ((13'(code[3:0]) + 13'h1) << code[6:4])))
      else $error("count outside its chord and step");

endmodule : light_sensor_top
`default_nettype wire

//--- verif/smbus_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module smbus_host_model
   import light_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic busDataOut,
   input  wire logic busDataOe,
   output logic      busClockPin,
   output logic      busDataPinIn
);
   logic sdaDrive;

   // Open-drain data wire with a pull-up: low whenever either party pulls it.
   assign busDataPinIn = sdaDrive & ~(busDataOe & ~busDataOut);

   // The clock stands high between frames, as a real host leaves it.
   initial begin
      busClockPin = 1'b1;
      sdaDrive    = 1'b1;
   end

   task automatic quarter();
      repeat (2) @(negedge core_clk);
   endtask : quarter

   // Data changes only mid-low and holds through the high phase, one bit in 8 clocks.
   task automatic bitXfer(input logic b, output logic seen);
      quarter();
      sdaDrive = b;
      quarter();
      busClockPin = 1'b1;
      quarter();
      seen = busDataPinIn;
      quarter();
      busClockPin = 1'b0;
   endtask : bitXfer

   task automatic frameStart();
      quarter();
      sdaDrive = 1'b0;
      quarter();
      busClockPin = 1'b0;
   endtask : frameStart

   task automatic frameStop();
      quarter();
      sdaDrive = 1'b0;
      quarter();
      busClockPin = 1'b1;
      quarter();
      sdaDrive = 1'b1;
      quarter();
   endtask : frameStop

   // Bytes go out MSB first; the ninth bit is the device's acknowledge.
   task automatic byteOut(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bitXfer(d[i], s);
      bitXfer(1'b1, s);
      ack = ~s;
   endtask : byteOut

   task automatic byteIn(output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitXfer(1'b1, s);
         d[i] = s;
      end
      bitXfer(1'b1, s);
   endtask : byteIn

   // Send Byte; holdCyc keeps the clock low after the address to provoke a timeout.
   task automatic sendByte(input logic [6:0] addr, input logic [7:0] cmd, input int holdCyc,
                           output logic ackA, output logic ackD);
      frameStart();
      byteOut({addr, 1'b0}, ackA);
      repeat (holdCyc) @(negedge core_clk);
      byteOut(cmd, ackD);
      frameStop();
   endtask : sendByte

   task automatic recvByte(input logic [6:0] addr, output logic [7:0] d, output logic ack);
      frameStart();
      byteOut({addr, 1'b1}, ack);
      byteIn(d);
      frameStop();
   endtask : recvByte
endmodule : smbus_host_model
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import light_pkg::*;
   logic       core_clk;
   logic       rst;
   logic       pulse0;
   logic       busClockPin;
   logic       busDataPinIn;
   logic       busDataOut;
   logic       busDataOe;
   logic [7:0] rd;
   logic       ackA;
   logic       ackD;
   int         n_mismatch = 0;
   int         n_compared = 0;

   light_sensor_top #(.STD_CONV_CYCLES(200), .EXT_CONV_CYCLES(136), .TIMEOUT_CYCLES(100))
      light_sensor_top_inst (.core_clk(core_clk), .rst(rst), .busClockPin(busClockPin),
      .busDataPinIn(busDataPinIn), .busDataOut(busDataOut), .busDataOe(busDataOe),
      .lightPulse({1'b0, pulse0}));

   smbus_host_model smbus_host_model_inst (.core_clk(core_clk), .busDataOut(busDataOut),
      .busDataOe(busDataOe), .busClockPin(busClockPin), .busDataPinIn(busDataPinIn));

   // 20 MHz core clock.
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // Channel 0 light: period 8, so any 200-cycle window holds 25 edges and 136 holds 17.
   // Counts of 24 or 16 give the same code, so an edge lost at the period turn is harmless.
   initial begin
      pulse0 = 1'b0;
      forever begin
         repeat (4) @(negedge core_clk);
         pulse0 = ~pulse0;
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
      end
   endtask : check

   task automatic conclude();
      if (n_mismatch == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : conclude

   task automatic wr(input logic [7:0] cmd);
      smbus_host_model_inst.sendByte(SLAVE_ADDR, cmd, 0, ackA, ackD);
      check({6'h00, ackA, ackD}, 8'h03);
   endtask : wr

   task automatic rdExp(input logic [7:0] exp);
      smbus_host_model_inst.recvByte(SLAVE_ADDR, rd, ackA);
      check({rd[6:0], ackA}, {exp[6:0], 1'b1});
      check(rd, exp);
   endtask : rdExp

   // Main sequence; waits are long enough for whole conversion periods to pass.
   initial begin
      rst = 1'b1;
      repeat (2) @(negedge core_clk);
      rst = 1'b0;
      repeat (3) @(negedge core_clk);
      rdExp(8'h00);
      smbus_host_model_inst.sendByte(7'h3a, CMD_POWER_UP, 0, ackA, ackD);
      check({6'h00, ackA, ackD}, 8'h00);
      rdExp(8'h00);
      wr(CMD_POWER_UP);
      rdExp(8'h03);
      wr(CMD_POWER_DOWN);
      repeat (600) @(negedge core_clk);
      wr(CMD_SEL_CH0);
      rdExp(8'h00);
      repeat (400) @(negedge core_clk);
      rdExp(8'h94);
      wr(CMD_SEL_CH1);
      rdExp(8'h80);
      rdExp(8'h80);
      wr(CMD_EXT_RANGE);
      wr(CMD_SEL_CH0);
      repeat (800) @(negedge core_clk);
      rdExp(8'h90);
      wr(CMD_STD_RANGE);
      repeat (800) @(negedge core_clk);
      rdExp(8'h94);
      wr(CMD_POWER_UP);
      smbus_host_model_inst.sendByte(SLAVE_ADDR, CMD_POWER_DOWN, 150, ackA, ackD);
      check({7'h00, ackD}, 8'h00);
      rdExp(8'h03);
      conclude();
   end

   // Watchdog well beyond the roughly 5900 cycles the sequence needs.
   initial begin
      repeat (40000) @(negedge core_clk);
      n_mismatch++;
      conclude();
   end
endmodule : testbench
`default_nettype wire
